//--- dv/hpl_port_link_led_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module hpl_port_link_led_monitor (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [2:0] ledAttributeSelect,
   input wire hpl_pkg::hpl_tp_in_t tpIn,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [3:0] linkPulseReq,
   input wire logic [3:0] repeatEnable,
   input wire logic [3:0] rxInvert,
   input wire logic attachReversed,
   input wire logic [4:0] ledBankAPortDriveOe,
   input wire logic [4:0] ledBankBPortDriveOe,
   input wire logic globalLedADriveOe,
   input wire logic globalLedBDriveOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [15:0] ctrl;
   logic [2:0] sinceRst;
   // mirror of the control word; polarity bits are not trusted
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl <= 16'h00FF;
         sinceRst <= 3'h0;
      end else begin
         if (wr && addr == 4'h0) ctrl <= wdata;
         if (sinceRst != 3'h7) sinceRst <= sinceRst + 3'h1;
      end
   end
   read_idle_a: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
   unmapped_read_a: assert property (rd && addr > 4'h1 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   status_read_a: assert property (rd && addr == 4'h1 |=> rdata[11] == $past(attachReversed)
      && rdata[15] == 1'b0 && rdata[7:4] == $past(rxInvert)) else $error("status word wrong");
   ctrl_read_a: assert property (rd && addr == 4'h0 |=> rdata[7:0] == $past(ctrl[7:0]))
      else $error("control read wrong");
   attach_hold_a: assert property (sinceRst == 3'h7 |-> $stable(attachReversed))
      else $error("attach mode changed");
   pulse_single_a: assert property (linkPulseReq[0] |=> !linkPulseReq[0])
      else $error("pulse request too long");
   pulse_quiet_a: assert property (tpIn.txActive[2] [*2] |=> !linkPulseReq[2])
      else $error("pulse while transmitting");
   pulse_enable_a: assert property (!ctrl[5] [*2] |=> !linkPulseReq[1])
      else $error("pulse while disabled");
   test_off_a: assert property (!ctrl[1] [*2] |=> repeatEnable[1])
      else $error("link fail with test off");
   override_on_a: assert property ((ctrl[12] && ctrl[15:14] == 2'h3) [*2]
      |=> ledBankAPortDriveOe == 5'h1F && globalLedADriveOe) else $error("override A not lit");
   override_off_a: assert property ((ctrl[13] && ctrl[15:14] == 2'h0) [*2]
      |=> ledBankBPortDriveOe == 5'h00 && !globalLedBDriveOe) else $error("override B not off");
   select_blank_a: assert property ((ledAttributeSelect == 3'h2 && ctrl[13:12] == 2'h0) [*6]
      |=> {ledBankAPortDriveOe, ledBankBPortDriveOe, globalLedADriveOe, globalLedBDriveOe} == 12'h000)
      else $error("reserved select lit");
   cover property (linkPulseReq[0]);
   cover property ($rose(repeatEnable[0]));
   cover property ($rose(rxInvert[2]));
endmodule
bind hpl_port_link_led hpl_port_link_led_monitor i_mon (.clock(clock), .resetn(resetn),
   .ledAttributeSelect(ledAttributeSelect), .tpIn(tpIn), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .linkPulseReq(linkPulseReq), .repeatEnable(repeatEnable),
   .rxInvert(rxInvert), .attachReversed(attachReversed),
   .ledBankAPortDriveOe(ledBankAPortDriveOe), .ledBankBPortDriveOe(ledBankBPortDriveOe),
   .globalLedADriveOe(globalLedADriveOe), .globalLedBDriveOe(globalLedBDriveOe));

//--- dv/hpl_tp_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// twisted-pair link partners
// ----------------------------------------
module hpl_tp_partner (
   input wire logic clock,
   output hpl_pkg::hpl_tp_in_t tpIn
);
   initial tpIn = '0;
   // k: 0 link pulse, 1 packet, 2 negative delimiter
   task automatic strobe(input int k, input int p);
      @(posedge clock);
      case (k)
         0: tpIn.rxLinkPulse[p] <= 1'b1;
         1: tpIn.rxPacket[p] <= 1'b1;
         default: tpIn.rxNegPolarity[p] <= 1'b1;
      endcase
      @(posedge clock);
      tpIn.rxLinkPulse <= 4'h0;
      tpIn.rxPacket <= 4'h0;
      tpIn.rxNegPolarity <= 4'h0;
   endtask
   task automatic burst(input int p, input int n, input int gap);
      repeat (n) begin
         strobe(0, p);
         repeat (gap) @(posedge clock);
      end
   endtask
   task automatic busy(input int p, input int n);
      @(posedge clock);
      tpIn.txActive[p] <= 1'b1;
      repeat (n) @(posedge clock);
      tpIn.txActive[p] <= 1'b0;
   endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] selIn;
   logic serIn, attMode, wr, rd, gA, gB, attRev;
   logic [2:0] ledSel;
   logic [3:0] addr, pulseReq, repEn, rxInv;
   logic [15:0] wdata, rdata;
   logic [4:0] ledA, ledB;
   logic [31:0] seed = 32'h17;
   hpl_pkg::hpl_attr_t attr;
   hpl_pkg::hpl_tp_in_t tpIn;
   int errCount, nChecks, cycles, puls1, g;
   always #5 clock = ~clock;
   hpl_port_link_led #(.TICK_CYCLES(10)) i_dut (.clock(clock), .resetn(resetn),
      .selectInStrap(selIn), .serialInStrap(serIn), .attachPortModeStrap(attMode),
      .ledAttributeSelect(ledSel), .tpIn(tpIn), .attr(attr), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .linkPulseReq(pulseReq), .repeatEnable(repEn),
      .rxInvert(rxInv), .attachReversed(attRev), .ledBankAPortDriveOe(ledA),
      .ledBankBPortDriveOe(ledB), .globalLedADriveOe(gA), .globalLedBDriveOe(gB));
   hpl_tp_partner i_peer (.clock(clock), .tpIn(tpIn));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // {bank A, bank B} of a linked-up port with carrier and collision quiet
   function automatic logic [1:0] ledExp(input logic [2:0] s, input logic par);
      case (s)
         3'h0: return {~par, par};
         3'h1: return 2'h2;
         3'h2, 3'h3: return 2'h0;
         default: return {1'b1, par};
      endcase
   endfunction
   task automatic closeOut();
      if (errCount == 0 && nChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (pulseReq[1] === 1'b1) puls1++;
      if (cycles == 30000) begin
         errCount++;
         closeOut();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic gapTo(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (pulseReq[0] !== 1'b1 && n < 2000);
   endtask
   // reset released on a clock edge
   task automatic doReset();
      void'(rnd());
      resetn <= 1'b0;
      {selIn, serIn, attMode} <= seed[3:0];
      tick(2);
      resetn <= 1'b1;
      tick(6);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {addr, wdata, wr, rd, selIn, serIn, attMode} = '0;
      attr = '0;
      ledSel = 3'h6;
      repeat (2) begin
         doReset();
         rdChk(4'h1, {1'b0, ledSel, attMode, serIn, selIn, 8'h0F});
         `CHK(attRev, attMode)
         rdChk(4'h0, {4'h0, {4{~serIn}}, 8'hFF});
      end
      wrReg(4'h1, 16'hFFFF);
      rdChk(4'h1, {1'b0, ledSel, attMode, serIn, selIn, 8'h0F});
      rdChk(4'h9, 16'h0000);
      wrReg(4'h0, 16'h04DD);
      rdChk(4'h0, 16'h04DD);
      tick(2);
      `CHK(repEn, 4'h2)
      i_peer.burst(0, 3, int'(rnd() % 8));
      tick(2);
      `CHK(repEn[0], 1'b0)
      i_peer.burst(0, 1, 0);
      i_peer.strobe(1, 3);
      tick(2);
      `CHK(repEn, 4'hB)
      i_peer.strobe(2, 2);
      i_peer.strobe(2, 3);
      tick(2);
      `CHK(rxInv, 4'h4)
      for (int s = 0; s < 8; s++) begin
         void'(rnd());
         attr.partitioned[1] <= seed[0] & (s != 7);
         ledSel <= s[2:0];
         tick(9);
         `CHK({ledA[1], ledB[1]}, ledExp(s[2:0], attr.partitioned[1]))
      end
      attr.partitioned <= 5'h00;
      for (int b = 0; b < 2; b++) begin
         for (int r = 3; r >= 0; r -= 3) begin
            wrReg(4'h0, {r[1:0], b[0], ~b[0], 12'h4DD});
            tick(2);
            `CHK(b ? {ledB, gB} : {ledA, gA}, r == 3 ? 6'h3F : 6'h00)
         end
      end
      wrReg(4'h0, 16'h04DD);
      ledSel <= 3'h1;
      attr.carrier[1] <= 1'b1;
      tick(9);
      attr.carrier[1] <= 1'b0;
      tick(300);
      `CHK({ledB[1], gA}, 2'h3)
      tick(200);
      `CHK({ledB[1], gA}, 2'h0)
      puls1 = 0;
      i_peer.busy(2, 5);
      gapTo(g);
      gapTo(g);
      `CHK(g inside {[800:1700]}, 1'b1)
      `CHK(puls1, 0)
      i_peer.strobe(1, 0);
      i_peer.strobe(1, 3);
      tick(6300);
      `CHK(repEn, 4'hB)
      tick(7000);
      `CHK(repEn, 4'h2)
      closeOut();
   end
endmodule

//--- logic/hpl_map.svh
`ifndef HPL_MAP_SVH
`define HPL_MAP_SVH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define HPL_CLK_PERIOD_NS 10
`define HPL_TICK_US 100
`define HPL_TICK_CYCLES ((`HPL_TICK_US * 1000) / `HPL_CLK_PERIOD_NS)

// ----------------------------------------
// times in microseconds, derived tick counts and the link pulse count
// ----------------------------------------
`define HPL_LINK_IDLE_US 12000
`define HPL_LINK_IDLE_TICKS (`HPL_LINK_IDLE_US / `HPL_TICK_US)
`define HPL_LINK_FAIL_US 100000
`define HPL_LINK_FAIL_TICKS (`HPL_LINK_FAIL_US / `HPL_TICK_US)
`define HPL_STRETCH_US 4000
`define HPL_STRETCH_TICKS (`HPL_STRETCH_US / `HPL_TICK_US)
`define HPL_COL_SHORT_US 100
`define HPL_COL_SHORT_TICKS (`HPL_COL_SHORT_US / `HPL_TICK_US)
`define HPL_BLINK130_US 130000
`define HPL_BLINK260_US 260000
`define HPL_BLINK512_US 512000
`define HPL_BLINK1560_US 1560000
`define HPL_HALF_TICKS(us) ((us) / (2 * `HPL_TICK_US))
`define HPL_LINK_PULSES 4

// ----------------------------------------
// register map
// ----------------------------------------
`define HPL_ADDR_CONTROL 4'h0
`define HPL_ADDR_STATUS 4'h1
`define HPL_LINK_TEST_RST 4'hF
`define HPL_PULSE_TX_RST 4'hF

// ----------------------------------------
// strap pin vector fields
// ----------------------------------------
`define HPL_PIN_SEL_LO 0
`define HPL_PIN_SERIAL 2
`define HPL_PIN_ATTACH_PORT_MODE_STRAP 3
`define HPL_PIN_LED_LO 4

`endif

//--- logic/hpl_pkg.sv
package hpl_pkg;

   typedef enum logic [2:0] {
      HPL_SETTLE0 = 3'b000,
      HPL_SETTLE1 = 3'b001,
      HPL_SETTLE2 = 3'b010,
      HPL_SETTLE3 = 3'b011,
      HPL_CAPTURE = 3'b100,
      HPL_RUN = 3'b101
   } hpl_phase_t;

   typedef struct packed {
      logic [1:0] blinkRate;
      logic overrideB;
      logic overrideA;
      logic [3:0] polarityEn;
      logic [3:0] pulseTxEn;
      logic [3:0] linkTestEn;
   } hpl_ctrl_t;

   typedef struct packed {
      logic [3:0] rxLinkPulse;
      logic [3:0] rxPacket;
      logic [3:0] rxNegPolarity;
      logic [3:0] txActive;
   } hpl_tp_in_t;

   typedef struct packed {
      logic [4:0] carrier;
      logic [4:0] collision;
      logic [4:0] partitioned;
      logic [4:0] portDisabled;
      logic loopback;
      logic jabber;
   } hpl_attr_t;

   typedef struct packed {
      logic [4:0] bankA;
      logic [4:0] bankB;
      logic globalA;
      logic globalB;
   } hpl_led_t;

   typedef struct packed {
      logic [2:0][6:0] pinSync;
      logic [6:0] pinStable;
      hpl_phase_t phase;
      logic [1:0] selectIn;
      logic serialIn;
      logic attachReversed;
      hpl_ctrl_t ctrl;
      logic [13:0] tickCnt;
      logic tick;
      logic [3:0][9:0] idleCnt;
      logic [3:0][9:0] silenceCnt;
      logic [3:0][2:0] pulseCnt;
      logic [3:0] linkUp;
      logic [3:0] polDone;
      logic [3:0] rxInvert;
      logic [3:0] pulseReq;
      logic [4:0][5:0] crsCnt;
      logic [4:0][5:0] colCnt;
      logic [3:0][12:0] blinkCnt;
      logic [3:0] blinkPhase;
      hpl_led_t ledOe;
      logic [15:0] rdata;
   } hpl_state_t;

endpackage

//--- logic/hpl_port_link_led.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "hpl_map.svh"
module hpl_port_link_led #(
   parameter int TICK_CYCLES = `HPL_TICK_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [1:0] selectInStrap,
   input wire logic serialInStrap,
   input wire logic attachPortModeStrap,
   input wire logic [2:0] ledAttributeSelect,
   input wire hpl_pkg::hpl_tp_in_t tpIn,
   input wire hpl_pkg::hpl_attr_t attr,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic [3:0] linkPulseReq,
   output logic [3:0] repeatEnable,
   output logic [3:0] rxInvert,
   output logic attachReversed,
   output logic [4:0] ledBankAPortDriveOe,
   output logic [4:0] ledBankBPortDriveOe,
   output logic globalLedADriveOe,
   output logic globalLedBDriveOe
);

   hpl_pkg::hpl_state_t s;
   hpl_pkg::hpl_state_t n;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [5:0] stretch(input logic raw, input logic tick,
                                          input logic [5:0] cnt, input logic [5:0] len);
      if (raw)
         return len;
      if (tick && cnt != 6'h00)
         return cnt - 6'h01;
      return cnt;
   endfunction

   function automatic logic [12:0] halfPeriod(input int idx);
      case (idx)
         0: return 13'(`HPL_HALF_TICKS(`HPL_BLINK130_US));
         1: return 13'(`HPL_HALF_TICKS(`HPL_BLINK260_US));
         2: return 13'(`HPL_HALF_TICKS(`HPL_BLINK512_US));
         default: return 13'(`HPL_HALF_TICKS(`HPL_BLINK1560_US));
      endcase
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic crs;
      logic col;
      logic par;
      logic lnk;
      logic att;
      logic la;
      logic lb;
      logic ov;
      logic crsAny;
      logic colAny;
      logic b130;
      logic b260;
      logic b512;
      logic b1560;
      logic [5:0] colLen;
      logic [2:0] sel;
      crs = 1'b0;
      col = 1'b0;
      par = 1'b0;
      lnk = 1'b0;
      att = 1'b0;
      la = 1'b0;
      lb = 1'b0;
      crsAny = 1'b0;
      colAny = 1'b0;
      n = s;
      n.pulseReq = 4'h0;
      n.tick = 1'b0;
      sel = s.pinStable[`HPL_PIN_LED_LO +: 3];

      n.pinSync = {s.pinSync[1:0], ledAttributeSelect, attachPortModeStrap,
                   serialInStrap, selectInStrap};
      if (s.pinSync[1] == s.pinSync[2])
         n.pinStable = s.pinSync[2];

      case (s.phase)
         hpl_pkg::HPL_SETTLE0: n.phase = hpl_pkg::HPL_SETTLE1;
         hpl_pkg::HPL_SETTLE1: n.phase = hpl_pkg::HPL_SETTLE2;
         hpl_pkg::HPL_SETTLE2: n.phase = hpl_pkg::HPL_SETTLE3;
         hpl_pkg::HPL_SETTLE3: n.phase = hpl_pkg::HPL_CAPTURE;
         hpl_pkg::HPL_CAPTURE: begin
            n.phase = hpl_pkg::HPL_RUN;
            n.selectIn = s.pinStable[`HPL_PIN_SEL_LO +: 2];
            n.serialIn = s.pinStable[`HPL_PIN_SERIAL];
            n.attachReversed = s.pinStable[`HPL_PIN_ATTACH_PORT_MODE_STRAP];
         end
         hpl_pkg::HPL_RUN: n.phase = hpl_pkg::HPL_RUN;
         default: n.phase = hpl_pkg::HPL_SETTLE0;
      endcase

      // ----------------------------------------
      // register port
      // ----------------------------------------
      // latest write holds; in the capture cycle polarityEn comes from the serial strap instead
      if (wr && addr == `HPL_ADDR_CONTROL)
         n.ctrl = hpl_pkg::hpl_ctrl_t'(wdata);
      if (s.phase == hpl_pkg::HPL_CAPTURE)
         n.ctrl.polarityEn = {4{~s.pinStable[`HPL_PIN_SERIAL]}};
      n.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            `HPL_ADDR_CONTROL: n.rdata = s.ctrl;
            `HPL_ADDR_STATUS: n.rdata = {1'b0, sel, s.attachReversed, s.serialIn,
                                         s.selectIn, s.rxInvert, ~s.linkUp};
            default: n.rdata = 16'h0000;
         endcase
      end

      if (s.tickCnt == 14'(TICK_CYCLES - 1)) begin
         n.tickCnt = 14'h0000;
         n.tick = 1'b1;
      end else begin
         n.tickCnt = s.tickCnt + 14'h0001;
      end

      // ----------------------------------------
      // twisted-pair link
      // ----------------------------------------
      for (int p = 0; p < 4; p++) begin
         if (tpIn.txActive[p]) begin
            n.idleCnt[p] = 10'h000;
         end else if (s.idleCnt[p] == 10'(`HPL_LINK_IDLE_TICKS)) begin
            n.idleCnt[p] = 10'h000;
            n.pulseReq[p] = s.ctrl.pulseTxEn[p];
         end else if (s.tick) begin
            n.idleCnt[p] = s.idleCnt[p] + 10'h001;
         end

         if (tpIn.rxPacket[p] || tpIn.rxLinkPulse[p])
            n.silenceCnt[p] = 10'h000;
         else if (s.tick && s.silenceCnt[p] != 10'(`HPL_LINK_FAIL_TICKS))
            n.silenceCnt[p] = s.silenceCnt[p] + 10'h001;

         if (!s.ctrl.linkTestEn[p]) begin
            n.linkUp[p] = 1'b1;
         end else if (s.linkUp[p]) begin
            if (s.silenceCnt[p] == 10'(`HPL_LINK_FAIL_TICKS)) begin
               n.linkUp[p] = 1'b0;
               n.pulseCnt[p] = 3'h0;
               n.polDone[p] = 1'b0;
               n.rxInvert[p] = 1'b0;
            end
         end else if (tpIn.rxPacket[p]) begin
            n.linkUp[p] = 1'b1;
         end else if (tpIn.rxLinkPulse[p]) begin
            if (s.pulseCnt[p] == 3'(`HPL_LINK_PULSES - 1))
               n.linkUp[p] = 1'b1;
            else
               n.pulseCnt[p] = s.pulseCnt[p] + 3'h1;
         end else if (s.silenceCnt[p] == 10'(`HPL_LINK_FAIL_TICKS)) begin
            n.pulseCnt[p] = 3'h0;
         end

         if (!s.ctrl.polarityEn[p]) begin
            n.rxInvert[p] = 1'b0;
         end else if (!s.polDone[p] && tpIn.rxNegPolarity[p]) begin
            n.rxInvert[p] = 1'b1;
            n.polDone[p] = 1'b1;
         end
      end

      // ----------------------------------------
      // LED attributes
      // ----------------------------------------
      for (int b = 0; b < 4; b++) begin
         if (s.tick) begin
            if (s.blinkCnt[b] == halfPeriod(b) - 13'h0001) begin
               n.blinkCnt[b] = 13'h0000;
               n.blinkPhase[b] = ~s.blinkPhase[b];
            end else begin
               n.blinkCnt[b] = s.blinkCnt[b] + 13'h0001;
            end
         end
      end
      b130 = s.blinkPhase[0];
      b260 = s.blinkPhase[1];
      b512 = s.blinkPhase[2];
      b1560 = s.blinkPhase[3];

      case (s.ctrl.blinkRate)
         2'h0: ov = 1'b0;
         2'h1: ov = b512;
         2'h2: ov = b1560;
         default: ov = 1'b1;
      endcase

      colLen = (sel == 3'h7) ? 6'(`HPL_COL_SHORT_TICKS + 1) : 6'(`HPL_STRETCH_TICKS + 1);
      for (int p = 0; p < 5; p++) begin
         n.crsCnt[p] = stretch(attr.carrier[p], s.tick, s.crsCnt[p],
                               6'(`HPL_STRETCH_TICKS + 1));
         n.colCnt[p] = stretch(attr.collision[p], s.tick, s.colCnt[p], colLen);
         crs = attr.carrier[p] || s.crsCnt[p] != 6'h00;
         col = attr.collision[p] || s.colCnt[p] != 6'h00;
         par = attr.partitioned[p];
         att = (p == 0);
         lnk = att ? 1'b0 : s.linkUp[2'(p + 3)];
         crsAny = crsAny | crs;
         colAny = colAny | col;
         case (sel)
            3'h0: begin
               la = att ? attr.loopback : (lnk & ~par);
               lb = par;
            end
            3'h1: begin
               la = att ? attr.loopback : lnk;
               lb = crs;
            end
            3'h4: begin
               la = crs ? b260 : lnk;
               lb = col ? b260 : par;
            end
            3'h5: begin
               la = lnk;
               lb = par;
            end
            3'h6: begin
               la = crs ? b130 : (lnk | (par & ~att));
               lb = par | attr.portDisabled[p];
            end
            3'h7: begin
               la = par ? b1560 : lnk;
               lb = att ? par : col;
            end
            default: begin
               la = 1'b0;
               lb = 1'b0;
            end
         endcase
         n.ledOe.bankA[p] = s.ctrl.overrideA ? ov : la;
         n.ledOe.bankB[p] = s.ctrl.overrideB ? ov : lb;
      end

      case (sel)
         3'h0, 3'h1, 3'h6, 3'h7: begin
            la = crsAny;
            lb = colAny;
         end
         3'h4: begin
            la = crsAny & b260;
            lb = colAny & b260;
         end
         3'h5: begin
            la = crsAny ? b512 : colAny;
            lb = crsAny ? b512 : attr.jabber;
         end
         default: begin
            la = 1'b0;
            lb = 1'b0;
         end
      endcase
      n.ledOe.globalA = s.ctrl.overrideA ? ov : la;
      n.ledOe.globalB = s.ctrl.overrideB ? ov : lb;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.ctrl.linkTestEn <= `HPL_LINK_TEST_RST;
         s.ctrl.pulseTxEn <= `HPL_PULSE_TX_RST;
         s.phase <= hpl_pkg::HPL_SETTLE0;
      end else begin
         s <= n;
      end
   end

   assign rdata = s.rdata;
   assign linkPulseReq = s.pulseReq;
   assign repeatEnable = s.linkUp;
   assign rxInvert = s.rxInvert;
   assign attachReversed = s.attachReversed;
   assign ledBankAPortDriveOe = s.ledOe.bankA;
   assign ledBankBPortDriveOe = s.ledOe.bankB;
   assign globalLedADriveOe = s.ledOe.globalA;
   assign globalLedBDriveOe = s.ledOe.globalB;

endmodule
